// ---- src/pbrs_pkg.sv ----
// Constants for the push-button, reset and status output block.
// Assumes a single 40 MHz clock and a plain register port.
package pbrs_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int MS_TIME_PS = 1000000000;
   localparam int MS_CYCLES = MS_TIME_PS / CLK_PERIOD_PS;
   localparam int FAULT_PULSE_NS = 128000;
   localparam int FAULT_PULSE_CYCLES = (FAULT_PULSE_NS * 1000) / CLK_PERIOD_PS;
   localparam int RESET_RELEASE_MS = 400;
   localparam int RESET_RELEASE_CYCLES = RESET_RELEASE_MS * MS_CYCLES;
   localparam int MS_W = 16;
   // Hold-to-reset choices in milliseconds, picked by a 2-bit field
   localparam logic [15:0] HOLD_MS_0 = 16'h1388;
   localparam logic [15:0] HOLD_MS_1 = 16'h2328;
   localparam logic [15:0] HOLD_MS_2 = 16'h2af8;
   localparam logic [15:0] HOLD_MS_3 = 16'h3a98;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WAKE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_MASK = 8'h0c;
   localparam logic [7:0] REG_STATE = 8'h10;
   localparam logic [7:0] REG_SHIP = 8'h14;
   // ==========================================================
   // Control fields
   localparam int CTRL_CHG_IND_EN = 0;
   localparam int CTRL_LEVEL_SHIFT = 1;
   localparam int CTRL_RST_DLY_LO = 2;
   localparam logic [3:0] CTRL_RESET = 4'h1;
   localparam logic [15:0] WAKE1_RESET = 16'h0032;
   localparam logic [15:0] WAKE2_RESET = 16'h03e8;
   // Status and mask bits
   localparam int EV_W = 6;
   localparam int EV_WAKE1 = 0;
   localparam int EV_WAKE2 = 1;
   localparam int EV_RESET = 2;
   localparam int EV_FAULT = 3;
   localparam int EV_SHIP_WAKE = 4;
   localparam int EV_THERM = 5;
endpackage

// ---- src/pbrs_press_if.sv ----
// Carries press timing between the control logic and the press timer.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface pbrs_press_if;
   logic pressed;
   logic [15:0] wake1Ms;
   logic [15:0] wake2Ms;
   logic [15:0] holdMs;
   logic wake1Hit;
   logic wake2Hit;
   logic holdHit;
   modport ctl (output pressed, output wake1Ms, output wake2Ms, output holdMs,
      input wake1Hit, input wake2Hit, input holdHit);
   modport tmr (input pressed, input wake1Ms, input wake2Ms, input holdMs,
      output wake1Hit, output wake2Hit, output holdHit);
endinterface

// ---- src/pbrs_press_timer.sv ----
// Press-duration timer: counts whole milliseconds of continuous press.
// Assumes pressed is already synchronous to sys_clk.
`timescale 1ns/10ps
module pbrs_press_timer #(
   parameter int MS_CYCLES = pbrs_pkg::MS_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   pbrs_press_if.tmr prs
);
   // ==========================================================
   // Millisecond prescaler and press counter
   logic [31:0] tickCnt_q;
   logic [15:0] pressMs_q;
   logic w1_q, w2_q, h_q;
   wire tick = (tickCnt_q == 32'(MS_CYCLES - 1));
   wire [15:0] nextMs = pressMs_q + 16'h0001;
   // Wake events only count for thresholds below the hold time
   // A zero threshold is off; without the guard it would fire once the count saturates
   wire w1Due = tick && (nextMs == prs.wake1Ms) && (prs.wake1Ms < prs.holdMs)
      && (prs.wake1Ms != 16'h0000);
   wire w2Due = tick && (nextMs == prs.wake2Ms) && (prs.wake2Ms < prs.holdMs)
      && (prs.wake2Ms != 16'h0000);
   wire hDue = tick && (nextMs == prs.holdMs);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tickCnt_q <= 32'h0;
         pressMs_q <= 16'h0;
      end else if (!prs.pressed) begin
         tickCnt_q <= 32'h0;
         pressMs_q <= 16'h0;
      end else begin
         tickCnt_q <= tick ? 32'h0 : tickCnt_q + 32'h1;
         // Saturate so a very long hold never wraps into a second event
         if (tick && pressMs_q != 16'hffff)
            pressMs_q <= nextMs;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w1_q <= 1'b0;
         w2_q <= 1'b0;
         h_q <= 1'b0;
      end else begin
         w1_q <= prs.pressed && w1Due;
         w2_q <= prs.pressed && w2Due;
         h_q <= prs.pressed && hDue;
      end
   end

   assign prs.wake1Hit = w1_q;
   assign prs.wake2Hit = w2_q;
   assign prs.holdHit = h_q;
endmodule

// ---- src/pbrs_top.sv ----
// Push-button, reset and status output logic of a charge manager.
// Assumes all inputs synchronous to sys_clk; open-drain pins resolved outside.
//
// How it works
// - Status line driven low while a charge is in progress.
// - Status line released when charge done, disabled or in high-impedance mode.
// - Each fault event outside a running pulse gives one 128 us low pulse on the status line.
// - Charge indication shown only while the indicator enable bit is set.
// - Power-good pulled low while input lies inside its valid window.
// - Level-shift mode makes power-good follow the push-button level.
// - Reset output asserts after the button is held past the hold time.
// - Reset output releases 400 ms after it asserted.
// - Shorter presses raise interrupts at two programmable wake thresholds.
// - A button press takes the device out of ship mode.
// - Thermistor faults during charging are recorded for the host to read.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module pbrs_top #(
   parameter int MS_CYCLES = pbrs_pkg::MS_CYCLES,
   parameter int FAULT_PULSE_CYCLES = pbrs_pkg::FAULT_PULSE_CYCLES,
   parameter int RESET_RELEASE_CYCLES = pbrs_pkg::RESET_RELEASE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   input wire logic manualButtonIn,
   input wire logic chargeInProgress,
   input wire logic chargeDisabled,
   input wire logic chargerHiZ,
   input wire logic faultEvent,
   input wire logic vinAboveSleepOffset,
   input wire logic vinBelowOvervoltage,
   input wire logic thermistorSenseFault,
   output logic statusIntOut,
   output logic statusIntOe,
   output logic powerGoodOut,
   output logic powerGoodOe,
   output logic resetOut,
   output logic resetOe,
   output logic shipModeActive,
   output logic irq
);
   // ==========================================================
   // Reset-out sequencer states
   typedef enum logic [1:0] {
      RST_IDLE = 2'b01,
      RST_HOLD = 2'b10
   } pbrs_rst_e;

   pbrs_rst_e rstState_q, rstState_d;
   logic [3:0] ctrl_q;
   logic [31:0] wake_q;
   logic [5:0] status_q, status_d;
   logic [5:0] mask_q;
   logic ship_q;
   logic thermSeen_q;
   logic [31:0] rdData_q;
   logic [31:0] faultCnt_q;
   logic [31:0] relCnt_q;
   logic intOe_q, pgOe_q, rstOe_q, irq_q;

   // ==========================================================
   // Decoding
   function automatic logic [15:0] holdMsSel(input logic [1:0] sel);
      case (sel)
         2'd0: holdMsSel = pbrs_pkg::HOLD_MS_0;
         2'd1: holdMsSel = pbrs_pkg::HOLD_MS_1;
         2'd2: holdMsSel = pbrs_pkg::HOLD_MS_2;
         default: holdMsSel = pbrs_pkg::HOLD_MS_3;
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   wire wrCtrl = regWrStb && hit(regAddr, pbrs_pkg::REG_CTRL);
   wire wrWake = regWrStb && hit(regAddr, pbrs_pkg::REG_WAKE);
   wire wrStatus = regWrStb && hit(regAddr, pbrs_pkg::REG_STATUS);
   wire wrMask = regWrStb && hit(regAddr, pbrs_pkg::REG_MASK);
   wire wrShip = regWrStb && hit(regAddr, pbrs_pkg::REG_SHIP);
   wire chgIndEn = ctrl_q[pbrs_pkg::CTRL_CHG_IND_EN];
   wire levelShift = ctrl_q[pbrs_pkg::CTRL_LEVEL_SHIFT];
   wire [1:0] rstDlySel = ctrl_q[pbrs_pkg::CTRL_RST_DLY_LO +: 2];
   wire pressed = !manualButtonIn;

   // ==========================================================
   // Press timer
   pbrs_press_if prs ();
   assign prs.pressed = pressed;
   assign prs.wake1Ms = wake_q[15:0];
   assign prs.wake2Ms = wake_q[31:16];
   assign prs.holdMs = holdMsSel(rstDlySel);

   pbrs_press_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .prs(prs)
   );

   // ==========================================================
   // Control registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= pbrs_pkg::CTRL_RESET;
         wake_q <= {pbrs_pkg::WAKE2_RESET, pbrs_pkg::WAKE1_RESET};
         mask_q <= 6'h00;
      end else begin
         if (wrCtrl)
            ctrl_q <= regWrData[3:0];
         if (wrWake)
            wake_q <= regWrData;
         if (wrMask)
            mask_q <= regWrData[5:0];
      end
   end

   // ==========================================================
   // Ship mode and thermistor record
   wire shipWake = ship_q && pressed;
   wire thermEv = thermistorSenseFault && chargeInProgress;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ship_q <= 1'b0;
         thermSeen_q <= 1'b0;
      end else begin
         // Press wins over a same-cycle entry request
         if (pressed)
            ship_q <= 1'b0;
         else if (wrShip && regWrData[0])
            ship_q <= 1'b1;
         thermSeen_q <= thermEv;
      end
   end

   // ==========================================================
   // Reset-out sequencer
   wire relDone = (relCnt_q == 32'(RESET_RELEASE_CYCLES - 1));

   always_comb begin
      rstState_d = rstState_q;
      case (rstState_q)
         RST_IDLE: begin
            if (prs.holdHit)
               rstState_d = RST_HOLD;
         end
         RST_HOLD: begin
            if (relDone)
               rstState_d = RST_IDLE;
         end
         default: rstState_d = RST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstState_q <= RST_IDLE;
         relCnt_q <= 32'h0;
      end else begin
         rstState_q <= rstState_d;
         relCnt_q <= (rstState_q == RST_HOLD && !relDone) ? relCnt_q + 32'h1 : 32'h0;
      end
   end

   // ==========================================================
   // Fault pulse on the status line
   wire faultBusy = (faultCnt_q != 32'h0);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         faultCnt_q <= 32'h0;
      else if (faultEvent && !faultBusy)
         faultCnt_q <= 32'(FAULT_PULSE_CYCLES);
      else if (faultBusy)
         faultCnt_q <= faultCnt_q - 32'h1;
   end

   // ==========================================================
   // Pin drivers
   wire chgShow = chgIndEn && chargeInProgress && !chargeDisabled && !chargerHiZ;
   wire vinValid = vinAboveSleepOffset && vinBelowOvervoltage;
   wire pgPull = levelShift ? pressed : vinValid;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         intOe_q <= 1'b0;
         pgOe_q <= 1'b0;
         rstOe_q <= 1'b0;
      end else begin
         // A fault pulse overrides the charge level while it lasts
         intOe_q <= chgShow || (faultEvent && !faultBusy) || (faultCnt_q > 32'h1);
         pgOe_q <= pgPull;
         rstOe_q <= (rstState_d == RST_HOLD);
      end
   end

   // ==========================================================
   // Events and interrupt
   logic [5:0] events;
   always_comb begin
      events = 6'h00;
      events[pbrs_pkg::EV_WAKE1] = prs.wake1Hit;
      events[pbrs_pkg::EV_WAKE2] = prs.wake2Hit;
      events[pbrs_pkg::EV_RESET] = prs.holdHit && rstState_q == RST_IDLE;
      events[pbrs_pkg::EV_FAULT] = faultEvent;
      events[pbrs_pkg::EV_SHIP_WAKE] = shipWake;
      events[pbrs_pkg::EV_THERM] = thermEv && !thermSeen_q;
   end

   // Set wins over a write-one clear in the same cycle
   assign status_d = (status_q & ~(wrStatus ? regWrData[5:0] : 6'h00)) | events;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= 6'h00;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
      end
   end

   // ==========================================================
   // Read port
   wire [31:0] stateWord = {24'h0, rstState_q == RST_HOLD, thermSeen_q, ship_q,
      manualButtonIn, vinValid, chargeInProgress, levelShift, chgIndEn};
   wire [31:0] rdMux =
      hit(regAddr, pbrs_pkg::REG_CTRL) ? {28'h0, ctrl_q} :
      hit(regAddr, pbrs_pkg::REG_WAKE) ? wake_q :
      hit(regAddr, pbrs_pkg::REG_STATUS) ? {26'h0, status_q} :
      hit(regAddr, pbrs_pkg::REG_MASK) ? {26'h0, mask_q} :
      hit(regAddr, pbrs_pkg::REG_STATE) ? stateWord :
      hit(regAddr, pbrs_pkg::REG_SHIP) ? {31'h0, ship_q} : 32'h0;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         rdData_q <= 32'h0;
      else
         rdData_q <= regRdStb ? rdMux : 32'h0;
   end

   assign regRdData = rdData_q;
   assign statusIntOut = 1'b0;
   assign statusIntOe = intOe_q;
   assign powerGoodOut = 1'b0;
   assign powerGoodOe = pgOe_q;
   assign resetOut = 1'b0;
   assign resetOe = rstOe_q;
   assign shipModeActive = ship_q;
   assign irq = irq_q;
endmodule

// ---- tb/pbrs_checker.sv ----
// Port-level assertions for the push-button, reset and status block.
// Assumes the bench sets short timing parameters and an eight-cycle fault pulse.
`timescale 1ns/10ps
module pbrs_checker #(
   parameter int MS_CYCLES = 4,
   parameter int RESET_RELEASE_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic regRdStb,
   input wire logic [31:0] regRdData,
   input wire logic manualButtonIn,
   input wire logic chargeInProgress,
   input wire logic chargeDisabled,
   input wire logic chargerHiZ,
   input wire logic faultEvent,
   input wire logic vinAboveSleepOffset,
   input wire logic vinBelowOvervoltage,
   input wire logic statusIntOe,
   input wire logic powerGoodOe,
   input wire logic resetOe,
   input wire logic shipModeActive
);
   localparam int HOLD_MIN = 5000 * MS_CYCLES;
   logic [31:0] lowCnt_q;
   logic [31:0] rstCnt_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Counters for spans too long to unroll
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lowCnt_q <= 32'h0;
         rstCnt_q <= 32'h0;
      end else begin
         lowCnt_q <= manualButtonIn ? 32'h0 : lowCnt_q + 32'h1;
         rstCnt_q <= resetOe ? rstCnt_q + 32'h1 : 32'h0;
      end
   end
   // ==========================================================
   // Properties
   status_cause_a: assert property ($rose(statusIntOe) |->
      $past(faultEvent) || $past(chargeInProgress && !chargeDisabled && !chargerHiZ))
      else $error("status line rose without cause");
   // Literal count: only valid while the bench keeps the pulse at eight cycles
   fault_pulse_a: assert property ($rose(statusIntOe) && !$past(chargeInProgress) |->
      statusIntOe [*8] ##1 !statusIntOe) else $error("fault pulse length wrong");
   power_good_a: assert property (powerGoodOe && $past(manualButtonIn) |->
      $past(vinAboveSleepOffset && vinBelowOvervoltage)) else $error("power good bad");
   reset_hold_a: assert property ($rose(resetOe) |-> lowCnt_q >= HOLD_MIN)
      else $error("reset asserted too early");
   reset_len_a: assert property ($fell(resetOe) |-> rstCnt_q == RESET_RELEASE_CYCLES)
      else $error("reset released at wrong time");
   reset_max_a: assert property (resetOe |-> rstCnt_q < RESET_RELEASE_CYCLES)
      else $error("reset held too long");
   ship_wake_a: assert property ($past(shipModeActive) && !$past(manualButtonIn) |->
      !shipModeActive) else $error("ship mode kept through press");
   read_idle_a: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
      else $error("read data outside read cycle");
endmodule
bind pbrs_top pbrs_checker #(.MS_CYCLES(MS_CYCLES),
   .RESET_RELEASE_CYCLES(RESET_RELEASE_CYCLES)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
   .regRdStb(regRdStb), .regRdData(regRdData), .manualButtonIn(manualButtonIn),
   .chargeInProgress(chargeInProgress), .chargeDisabled(chargeDisabled),
   .chargerHiZ(chargerHiZ), .faultEvent(faultEvent),
   .vinAboveSleepOffset(vinAboveSleepOffset), .vinBelowOvervoltage(vinBelowOvervoltage),
   .statusIntOe(statusIntOe), .powerGoodOe(powerGoodOe), .resetOe(resetOe),
   .shipModeActive(shipModeActive));

// ---- tb/pbrs_button_model.sv ----
// Push-button partner: holds the button low for a requested span.
// Assumes one request at a time; a released button reads high via its pull-up.
`timescale 1ns/10ps
module pbrs_button_model (
   input wire logic sys_clk,
   input wire logic pressGo,
   input wire logic [31:0] pressLen,
   output logic manualButtonIn
);
   logic [31:0] left_q = 32'h0;
   assign manualButtonIn = (left_q == 32'h0);
   always @(posedge sys_clk) begin
      if (pressGo)
         left_q <= pressLen;
      else if (left_q != 32'h0)
         left_q <= left_q - 32'h1;
   end
endmodule

// ---- tb/test_pbrs_top.sv ----
// Self-checking bench for the push-button, reset and status block.
// Assumes the button model and checker beside the design, short timing parameters.
`timescale 1ns/10ps
module test_pbrs_top;
   localparam int MSC = 4;
   localparam int RRC = 20;
   localparam int HOLDC = 5000 * MSC;
   logic sys_clk = 1'b0, resetn = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, rdSeen = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0, pressLen = 32'h0, regRdData, seed = 32'h94755382;
   logic chargeInProgress = 1'b0, chargeDisabled = 1'b0, chargerHiZ = 1'b0, pressGo = 1'b0;
   logic faultEvent = 1'b0, vinAboveSleepOffset = 1'b0, vinBelowOvervoltage = 1'b0;
   logic thermistorSenseFault = 1'b0, manualButtonIn, statusIntOut, statusIntOe;
   logic powerGoodOut, powerGoodOe, resetOut, resetOe, shipModeActive, irq;
   int bad_count = 0;
   int checked = 0;
   logic [31:0] expQ[$];
   string nameQ[$];
   pbrs_top #(.MS_CYCLES(MSC), .FAULT_PULSE_CYCLES(8), .RESET_RELEASE_CYCLES(RRC)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .manualButtonIn(manualButtonIn), .chargeInProgress(chargeInProgress),
      .chargeDisabled(chargeDisabled), .chargerHiZ(chargerHiZ), .faultEvent(faultEvent),
      .vinAboveSleepOffset(vinAboveSleepOffset), .vinBelowOvervoltage(vinBelowOvervoltage),
      .thermistorSenseFault(thermistorSenseFault), .statusIntOut(statusIntOut),
      .statusIntOe(statusIntOe), .powerGoodOut(powerGoodOut), .powerGoodOe(powerGoodOe),
      .resetOut(resetOut), .resetOe(resetOe), .shipModeActive(shipModeActive), .irq(irq));
   pbrs_button_model u_button (.sys_clk(sys_clk), .pressGo(pressGo), .pressLen(pressLen),
      .manualButtonIn(manualButtonIn));
   initial forever #12.5 sys_clk = ~sys_clk;
   // ==========================================================
   // Tasks
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Strobe drops for one cycle after each access so no signal is driven twice per step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      cyc(1);
      regWrStb <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      expQ.push_back(e);
      nameQ.push_back(nm);
      regAddr <= a;
      regRdStb <= 1'b1;
      cyc(1);
      regRdStb <= 1'b0;
      cyc(1);
   endtask
   task automatic st(input logic [31:0] e, input string nm);
      rd(pbrs_pkg::REG_STATUS, e, nm);
   endtask
   task automatic go(input int n);
      pressLen <= n;
      pressGo <= 1'b1;
      cyc(1);
      pressGo <= 1'b0;
   endtask
   task automatic press(input int n);
      go(n);
      cyc(n + 2);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // Read data monitor: pairs each answer with the oldest note
   always @(posedge sys_clk) begin
      if (rdSeen === 1'b1 && expQ.size() > 0)
         chk(nameQ.pop_front(), expQ.pop_front(), regRdData);
      rdSeen <= regRdStb;
   end
   initial begin
      #2000000;
      bad_count++;
      conclude();
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      int n;
      cyc(2);
      resetn <= 1'b1;
      rd(pbrs_pkg::REG_CTRL, 32'h1, "ctrl");
      rd(pbrs_pkg::REG_WAKE, 32'h03e80032, "wake");
      st(32'h0, "status");
      rd(pbrs_pkg::REG_MASK, 32'h0, "mask");
      rd(8'h20, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr(pbrs_pkg::REG_WAKE, r);
         wr(pbrs_pkg::REG_MASK, r);
         rd(pbrs_pkg::REG_WAKE, r, "wake");
         rd(pbrs_pkg::REG_MASK, r & 32'h3f, "mask");
      end
      chargeInProgress <= 1'b1;
      cyc(2);
      chk("charging", 1, statusIntOe);
      chargeDisabled <= 1'b1;
      cyc(2);
      chk("disabled", 0, statusIntOe);
      chargeDisabled <= 1'b0;
      chargerHiZ <= 1'b1;
      cyc(2);
      chk("hiZ", 0, statusIntOe);
      chargerHiZ <= 1'b0;
      wr(pbrs_pkg::REG_CTRL, 32'h0);
      cyc(1);
      chk("indicatorOff", 0, statusIntOe);
      chargeInProgress <= 1'b0;
      wr(pbrs_pkg::REG_MASK, 32'h3f);
      faultEvent <= 1'b1;
      cyc(1);
      faultEvent <= 1'b0;
      cyc(2);
      chk("faultPulse", 1, statusIntOe);
      cyc(8);
      chk("faultEnd", 0, statusIntOe);
      chk("irqFault", 1, irq);
      st(32'h8, "faultStatus");
      wr(pbrs_pkg::REG_STATUS, 32'h3f);
      st(32'h0, "cleared");
      for (int i = 0; i < 4; i++) begin
         vinAboveSleepOffset <= i[0];
         vinBelowOvervoltage <= i[1];
         cyc(2);
         chk("powerGood", i == 3, powerGoodOe);
      end
      wr(pbrs_pkg::REG_CTRL, 32'h3);
      cyc(1);
      chk("shiftIdle", 0, powerGoodOe);
      go(6);
      cyc(3);
      chk("shiftPress", 1, powerGoodOe);
      cyc(5);
      chk("shiftRelease", 0, powerGoodOe);
      wr(pbrs_pkg::REG_CTRL, 32'h1);
      wr(pbrs_pkg::REG_WAKE, {16'd4, 16'd2});
      wr(pbrs_pkg::REG_STATUS, 32'h3f);
      press(6);
      press(6);
      st(32'h0, "shortPress");
      press(12);
      st(32'h1, "wake1");
      press(20);
      st(32'h3, "wake2");
      chk("irqWake", 1, irq);
      wr(pbrs_pkg::REG_MASK, 32'h0);
      cyc(1);
      chk("irqMasked", 0, irq);
      wr(pbrs_pkg::REG_STATUS, 32'h3);
      st(32'h0, "cleared");
      go(HOLDC + 100);
      n = 0;
      while (resetOe !== 1'b1 && n < HOLDC + 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      chk("holdSpan", HOLDC + 2, n);
      st(32'h7, "holdStatus");
      cyc(RRC - 2);
      chk("resetOff", 0, resetOe);
      cyc(60);
      chk("resetStays", 0, resetOe);
      cyc(60);
      wr(pbrs_pkg::REG_CTRL, 32'h5);
      wr(pbrs_pkg::REG_STATUS, 32'h3f);
      press(HOLDC + 40);
      st(32'h3, "holdSelect");
      wr(pbrs_pkg::REG_CTRL, 32'h1);
      wr(pbrs_pkg::REG_STATUS, 32'h3f);
      wr(pbrs_pkg::REG_SHIP, 32'h1);
      chk("shipOn", 1, shipModeActive);
      press(3);
      chk("shipOff", 0, shipModeActive);
      st(32'h10, "shipWake");
      resetn <= 1'b0;
      cyc(2);
      resetn <= 1'b1;
      rd(pbrs_pkg::REG_CTRL, 32'h1, "ctrlAgain");
      rd(pbrs_pkg::REG_WAKE, 32'h03e80032, "wakeAgain");
      chargeInProgress <= 1'b1;
      thermistorSenseFault <= 1'b1;
      cyc(3);
      st(32'h20, "thermistor");
      rd(pbrs_pkg::REG_STATE, 32'h5d, "state");
      chk("odData", 0, {statusIntOut, powerGoodOut, resetOut});
      cyc(2);
      conclude();
   end
endmodule
